//--- ofp_core.sv
// Purpose: protection sequencer for five high-side output channels
// Assumes: analog comparators give raw fault levels; threshold choice is driven out
// Notes:   register port answers reads one cycle later, never stalls
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module ofp_core
    import ofp_pkg::*;
#(
    parameter int P_W1      = CYC_WIN1,
    parameter int P_W2      = CYC_WIN2,
    parameter int P_W3      = CYC_WIN3,
    parameter int P_RESTART = CYC_RESTART,
    parameter int P_BLANK   = CYC_BLANK
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [7:0]          addr,
    input  wire logic [31:0]         wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [31:0]         rdata,
    input  wire logic                fail_mode_in,
    input  wire logic                die_hot_in,
    input  wire logic [NCH-1:0]      oc_raw,
    input  wire logic [NCH-1:0]      ssc_raw,
    input  wire logic [NCH-1:0]      warn_hi_raw,
    input  wire logic [NCH-1:0]      warn_lo_raw,
    input  wire logic [NCH-1:0]      shut_raw,
    input  wire logic [NCH-1:0]      vout_low_raw,
    output logic      [NCH-1:0]      out_en,
    output logic      [3*NCH-1:0]    inrush_level,
    output logic                     thr1_derate,
    output logic      [NCH-1:0]      thr_half
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam int CW = $clog2((P_W3 > P_RESTART ? P_W3 : P_RESTART) + 1);
    localparam int BW = $clog2(P_BLANK + 1);
    typedef struct packed {
        logic [SYW-1:0]               s1;
        logic [SYW-1:0]               s2;
        logic [SYW-1:0]               s3;
        logic [SYW-1:0]               cl;
        logic [2:0]                   cfg;
        logic [NCH-1:0]               on;
        logic [NCH-1:0]               half;
        ofp_stage_e [NCH-1:0]         stg;
        logic [NCH-1:0][CW-1:0]       wcnt;
        logic [NCH-1:0][CW-1:0]       rcnt;
        logic [NCH-1:0]               warn;
        logic [NCH-1:0]               tsd;
        logic [NCH-1:0]               ocf;
        logic [NCH-1:0]               foff;
        logic [NCH-1:0]               latch;
        logic [NCH-1:0]               rpend;
        logic [BW-1:0]                bcnt;
        logic                         blank;
        logic                         fail_prev;
        logic [NCH-1:0]               out;
        logic [3*NCH-1:0]             lvl;
        logic                         tder;
        logic [NCH-1:0]               thalf;
        logic [31:0]                  rdata;
    } ofp_core_s;
    ofp_core_s s_r;
    ofp_core_s s_nxt;

    logic [SYW-1:0] raw;
    logic [NCH-1:0] ocg;
    logic [NCH-1:0] scg;
    logic [NCH-1:0] otg;
    logic [NCH-1:0] wq;
    logic [NCH-1:0] tq;
    logic [NCH-1:0] ocq;
    logic [NCH-1:0] scq;
    logic           fail;
    logic           mchg;

    assign raw = {vout_low_raw, shut_raw, warn_lo_raw, warn_hi_raw,
                  ssc_raw, oc_raw, die_hot_in, fail_mode_in};
    assign fail = s_r.cl[SY_FAIL];
    assign mchg = fail != s_r.fail_prev;
    // ----------------------------------------------------------------
    // deglitch filters
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++) begin : g_flt
        ofp_glitch #(.N(CYC_OC_GLITCH)) u_oc (
            .clk(clk), .rst(rst), .d(s_r.cl[SY_OC + g]), .q(ocg[g])
        );
        ofp_glitch #(.N(CYC_OC_GLITCH)) u_ssc (
            .clk(clk), .rst(rst), .d(s_r.cl[SY_SSC + g]), .q(scg[g])
        );
        ofp_glitch #(.N(CYC_OT_GLITCH)) u_ot (
            .clk(clk), .rst(rst), .d(s_r.cl[SY_SHUT + g]), .q(otg[g])
        );
    end
    // blanking masks every detector except die-hot and vout-low, warnings included
    assign ocq = ocg & {NCH{~s_r.blank}};
    assign scq = scg & {NCH{~s_r.blank}};
    assign tq  = otg & {NCH{~s_r.blank}};
    // per-channel sensor, one of two thresholds
    assign wq  = (s_r.cfg[CFG_WSEL_BIT] ? s_r.cl[SY_WLO +: NCH]
                                        : s_r.cl[SY_WHI +: NCH])
                 & {NCH{~s_r.blank}};
    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [NCH-1:0] onw;
        logic [NCH-1:0] rdc;
        logic [CW-1:0]  lim;
        logic [31:0]    st;
        logic           hs;
        logic           lat;
        onw = '0;
        rdc = '0;
        lim = '0;
        st  = '0;
        hs  = 1'b0;
        lat = 1'b0;
        s_nxt = s_r;
        // three-stage sampling; a change counts once stages two and three agree
        s_nxt.s1 = raw;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        for (int b = 0; b < SYW; b++) begin
            if (s_r.s2[b] == s_r.s3[b]) begin
                s_nxt.cl[b] = s_r.s3[b];
            end
        end
        s_nxt.fail_prev = fail;
        if (s_r.blank) begin
            s_nxt.bcnt = s_r.bcnt + 1'b1;
            if (s_r.bcnt == BW'(P_BLANK - 1)) begin
                s_nxt.blank = 1'b0;
            end
        end
        if (wr) begin
            if (addr == ADDR_CFG) begin
                s_nxt.cfg = wdata[2:0];
            end
            if (addr == ADDR_OUT_CTRL) begin
                s_nxt.on = wdata[NCH-1:0];
                onw      = wdata[NCH-1:0];
            end
            for (int c = 0; c < NCH; c++) begin
                if (addr == 8'(ADDR_CH_CTRL0 + ADDR_STRIDE * c)) begin
                    s_nxt.on[c]   = wdata[CH_ON_BIT];
                    s_nxt.half[c] = wdata[CH_HALF_BIT];
                    onw[c]        = wdata[CH_ON_BIT];
                end
            end
        end
        s_nxt.rdata = '0;
        if (rd) begin
            if (addr == ADDR_CFG) begin
                s_nxt.rdata = 32'(s_r.cfg);
            end
            if (addr == ADDR_OUT_CTRL) begin
                s_nxt.rdata = 32'(s_r.on);
            end
            if (addr == ADDR_QSTAT) begin
                st[QS_WARN_LSB +: NCH] = s_r.warn;
                st[QS_TSD_LSB +: NCH]  = s_r.tsd;
                st[QS_OC_LSB +: NCH]   = s_r.ocf;
                s_nxt.rdata = st;
            end
            for (int c = 0; c < NCH; c++) begin
                if (addr == 8'(ADDR_CH_CTRL0 + ADDR_STRIDE * c)) begin
                    s_nxt.rdata = '0;
                    s_nxt.rdata[CH_ON_BIT]   = s_r.on[c];
                    s_nxt.rdata[CH_HALF_BIT] = s_r.half[c];
                end
                if (addr == 8'(ADDR_CH_STAT0 + ADDR_STRIDE * c)) begin
                    s_nxt.rdata = '0;
                    s_nxt.rdata[ST_WARN_BIT] = s_r.warn[c];
                    s_nxt.rdata[ST_TSD_BIT]  = s_r.tsd[c];
                    s_nxt.rdata[ST_OC_BIT]   = s_r.ocf[c];
                    s_nxt.rdata[ST_OUT_BIT]  = s_r.out[c];
                    s_nxt.rdata[ST_STG_LSB +: 3] = s_r.stg[c];
                    rdc[c] = 1'b1;
                end
            end
        end
        for (int c = 0; c < NCH; c++) begin
            // flags: cleared by a read only once the cause is gone; a new event wins
            if (rdc[c] && !wq[c]) begin
                s_nxt.warn[c] = 1'b0;
            end
            if (wq[c]) begin
                s_nxt.warn[c] = 1'b1;
            end
            if (rdc[c] && !tq[c]) begin
                s_nxt.tsd[c] = 1'b0;
            end
            if (tq[c]) begin
                s_nxt.tsd[c] = 1'b1;
            end
            if (rdc[c] && !ocq[c] && !scq[c]) begin
                s_nxt.ocf[c] = 1'b0;
            end
            if (ocq[c] || scq[c]) begin
                s_nxt.ocf[c] = 1'b1;
            end
            // restart paths
            if (!fail && onw[c] && !tq[c]) begin
                s_nxt.foff[c] = 1'b0;
            end
            if (s_r.rpend[c]) begin
                s_nxt.rcnt[c] = s_r.rcnt[c] + 1'b1;
                if (s_r.rcnt[c] == CW'(P_RESTART - 1)) begin
                    s_nxt.foff[c]  = 1'b0;
                    s_nxt.rpend[c] = 1'b0;
                end
            end
            if (mchg) begin
                s_nxt.foff[c]  = 1'b0;
                s_nxt.latch[c] = 1'b0;
                s_nxt.rpend[c] = 1'b0;
            end
            // shutdown; warnings alone never touch the output
            if (s_r.out[c] && (tq[c] || ocq[c] || scq[c])) begin
                lat = tq[c] || scq[c] || (ocq[c] && s_r.stg[c] == STG_W1);
                s_nxt.foff[c]  = 1'b1;
                s_nxt.latch[c] = fail && lat;
                s_nxt.rpend[c] = fail && !lat;
                s_nxt.rcnt[c]  = '0;
            end
            s_nxt.out[c] = s_r.on[c] && !s_nxt.foff[c];
            // inrush windows, counted only while the output is on
            hs = s_r.half[c] && !fail;
            case (s_r.stg[c])
                STG_W1:  lim = hs ? CW'(P_W1 / 2) : CW'(P_W1);
                STG_W2:  lim = hs ? CW'(P_W2 / 2) : CW'(P_W2);
                STG_W3:  lim = hs ? CW'(P_W3 / 2) : CW'(P_W3);
                default: lim = '0;
            endcase
            if (!s_nxt.out[c]) begin
                s_nxt.stg[c]  = STG_OFF;
                s_nxt.wcnt[c] = '0;
            end else if (s_r.stg[c] == STG_OFF) begin
                s_nxt.stg[c]  = STG_W1;
                s_nxt.wcnt[c] = '0;
            end else if (s_r.stg[c] != STG_STEADY) begin
                s_nxt.wcnt[c] = s_r.wcnt[c] + 1'b1;
                // >= lets a halving mid-window end it at once
                if (s_r.wcnt[c] >= lim - 1'b1) begin
                    s_nxt.wcnt[c] = '0;
                    case (s_r.stg[c])
                        STG_W1:  s_nxt.stg[c] = STG_W2;
                        STG_W2:  s_nxt.stg[c] = STG_W3;
                        default: s_nxt.stg[c] = STG_STEADY;
                    endcase
                end
            end
            s_nxt.lvl[3*c +: 3] = s_nxt.stg[c];
            s_nxt.thalf[c] = s_r.cfg[CFG_TON_BIT] && s_r.cl[SY_VLOW + c]
                             && s_nxt.stg[c] != STG_OFF && s_nxt.stg[c] != STG_STEADY;
        end
        s_nxt.tder = s_r.cfg[CFG_DIE_BIT] && s_r.cl[SY_DIE];
    end
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r       <= '0;
            s_r.cfg   <= CFG_RST;
            s_r.on    <= ON_RST;
            s_r.half  <= HALF_RST;
            s_r.blank <= 1'b1;  // reset doubles as wake-up
        end else begin
            s_r <= s_nxt;
        end
    end
    assign rdata        = s_r.rdata;
    assign out_en       = s_r.out;
    assign inrush_level = s_r.lvl;
    assign thr1_derate  = s_r.tder;
    assign thr_half     = s_r.thalf;
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_stat0_read;
        rd && addr == ADDR_CH_STAT0;
    endsequence
    sequence s_cool0;
        !wq[0];
    endsequence
    a_warn_set: assert property (wq[0] |=> s_r.warn[0] && $stable(out_en[0]) || !wq[0])
        else $error("warning flag not set");
    a_warn_keep: assert property (s_r.warn[0] && !(rd && addr == ADDR_CH_STAT0 && !wq[0])
        |=> s_r.warn[0])
        else $error("warning flag lost without read");
    a_warn_clear: assert property ((s_stat0_read ##0 s_cool0) |=> !s_r.warn[0])
        else $error("warning flag not cleared by read");
    a_tsd_off: assert property (tq[0] && s_r.out[0] |=> !out_en[0] && s_r.tsd[0])
        else $error("thermal shutdown did not switch off");
    a_fail_latch: assert property (s_r.latch[0] && !mchg |=> !out_en[0])
        else $error("latched output restarted in fail mode");
    a_win_start: assert property ($rose(s_r.out[0]) |-> s_r.stg[0] == STG_W1)
        else $error("first window not entered on turn-on");
    a_win_bound: assert property (s_r.stg[0] == STG_W1 |-> s_r.wcnt[0] < CW'(P_W1))
        else $error("first window overran");
    a_thr_half: assert property (thr_half[0]
        |-> $past(s_r.cfg[CFG_TON_BIT]) && $past(s_r.cl[SY_VLOW]))
        else $error("threshold halved without cause");
    a_die_derate: assert property (thr1_derate
        |-> $past(s_r.cfg[CFG_DIE_BIT]) && $past(s_r.cl[SY_DIE]))
        else $error("die derate without cause");
    a_restart_time: assert property ($fell(s_r.rpend[0]) && !$past(mchg) && !$past(s_r.out[0])
        |-> $past(s_r.rcnt[0]) == CW'(P_RESTART - 1) && !s_r.foff[0])
        else $error("auto-restart at wrong time");
    a_rd_unmapped: assert property (rd && addr == 8'hfc |=> rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

//--- ofp_glitch.sv
// Purpose: deglitch filter, output high after N+1 cycles of steady input
// Assumes: input already synchronised to clk
// Notes:   output drops with the input; callers latch what must persist
`timescale 1ns/1ps
module ofp_glitch
    import ofp_pkg::*;
#(
    parameter int N = CYC_OC_GLITCH
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    localparam int W = $clog2(N + 1);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         q;
    } ofp_glitch_s;
    ofp_glitch_s s_r;
    ofp_glitch_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!d) begin
            s_nxt.cnt = '0;
            s_nxt.q   = 1'b0;
        end else if (s_r.cnt == W'(N)) begin
            s_nxt.q = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign q = s_r.q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_glitch_full: assert property ($rose(q) |-> s_r.cnt == W'(N) && $past(d))
        else $error("filter fired before full count");
    a_glitch_drop: assert property (!d |=> !q && s_r.cnt == '0)
        else $error("filter did not restart on drop");
endmodule

//--- ofp_host.sv
// Purpose: host model that owns the register port of the protection block
// Assumes: one access per call; strobes last one cycle
// Notes:   every signal changes by nba at a rising edge; read data taken a cycle later
`timescale 1ns/1ps
module ofp_host (
    input  wire logic        clk,
    output logic      [7:0]  addr,
    output logic      [31:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [31:0] rdata
);
    initial begin
        addr  = 8'h00;
        wdata = 32'h0;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    // on-bit writes are how the host restarts a channel
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // a channel status read is the only way the host delatches flags
    task automatic read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        // data stand only in this cycle; taken mid-cycle, clear of both edges
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
endmodule

//--- ofp_pkg.sv
// Purpose: shared constants and types for the output fault protection block
// Assumes: 125 MHz core clock, five power channels
// Notes:   offsets are byte addresses on a 32-bit register port
package ofp_pkg;
    // ----------------------------------------------------------------
    // geometry and clock
    // ----------------------------------------------------------------
    localparam int NCH     = 5;
    localparam int CLK_MHZ = 125;
    // ----------------------------------------------------------------
    // times as printed, cycle counts derived from the clock
    // ----------------------------------------------------------------
    localparam int T_WIN1_US      = 2000;
    localparam int T_WIN2_US      = 8000;
    localparam int T_WIN3_US      = 64000;
    localparam int T_OC_GLITCH_NS = 2000;
    localparam int T_OT_GLITCH_NS = 5000;
    localparam int T_RESTART_US   = 64000;
    localparam int T_BLANK_US     = 50;
    localparam int CYC_WIN1       = T_WIN1_US * CLK_MHZ;
    localparam int CYC_WIN2       = T_WIN2_US * CLK_MHZ;
    localparam int CYC_WIN3       = T_WIN3_US * CLK_MHZ;
    localparam int CYC_OC_GLITCH  = T_OC_GLITCH_NS * CLK_MHZ / 1000;
    localparam int CYC_OT_GLITCH  = T_OT_GLITCH_NS * CLK_MHZ / 1000;
    localparam int CYC_RESTART    = T_RESTART_US * CLK_MHZ;
    localparam int CYC_BLANK      = T_BLANK_US * CLK_MHZ;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CFG      = 8'h00;
    localparam logic [7:0] ADDR_OUT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_QSTAT    = 8'h08;
    localparam logic [7:0] ADDR_CH_CTRL0 = 8'h10;
    localparam logic [7:0] ADDR_CH_STAT0 = 8'h30;
    localparam int         ADDR_STRIDE   = 4;
    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CFG_DIE_BIT  = 0;
    localparam int CFG_TON_BIT  = 1;
    localparam int CFG_WSEL_BIT = 2;
    localparam int CH_ON_BIT    = 0;
    localparam int CH_HALF_BIT  = 1;
    localparam int ST_WARN_BIT  = 0;
    localparam int ST_TSD_BIT   = 1;
    localparam int ST_OC_BIT    = 2;
    localparam int ST_OUT_BIT   = 3;
    localparam int ST_STG_LSB   = 4;
    localparam int QS_WARN_LSB  = 0;
    localparam int QS_TSD_LSB   = 5;
    localparam int QS_OC_LSB    = 10;
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [4:0] ON_RST  = 5'h00;
    localparam logic [4:0] HALF_RST = 5'h00;
    // ----------------------------------------------------------------
    // positions of the synchronised inputs
    // ----------------------------------------------------------------
    localparam int SY_FAIL = 0;
    localparam int SY_DIE  = 1;
    localparam int SY_OC   = 2;
    localparam int SY_SSC  = 7;
    localparam int SY_WHI  = 12;
    localparam int SY_WLO  = 17;
    localparam int SY_SHUT = 22;
    localparam int SY_VLOW = 27;
    localparam int SYW     = 32;
    typedef enum logic [2:0] {STG_OFF, STG_W1, STG_W2, STG_W3, STG_STEADY} ofp_stage_e;
endpackage

//--- tb.sv
// Purpose: self-checking bench for the output protection sequencer
// Assumes: shortened windows; deglitch counts stay at full length
// Notes:   outputs copied at the falling edge, compared after the rising one
`timescale 1ns/1ps
module tb;
    import ofp_pkg::*;
    localparam int W1 = 40;
    localparam int W2 = 80;
    localparam int W3 = 160;
    localparam int RS = 100;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic [7:0]       addr;
    logic [31:0]      wdata;
    logic             wr;
    logic             rd;
    logic [31:0]      rdata;
    logic             fail_mode_in = 1'b0;
    logic             die_hot_in = 1'b0;
    logic [NCH-1:0]   oc_raw = '0;
    logic [NCH-1:0]   warn_hi_raw = '0;
    logic [NCH-1:0]   warn_lo_raw = '0;
    logic [NCH-1:0]   shut_raw = '0;
    logic [NCH-1:0]   ssc_raw = '0;
    logic [NCH-1:0]   vout_low_raw = '0;
    logic [NCH-1:0]   out_en;
    logic [3*NCH-1:0] inrush_level;
    logic             thr1_derate;
    logic [NCH-1:0]   thr_half;
    logic [NCH-1:0]   out_en_w;
    logic [3*NCH-1:0] inrush_level_w;
    logic             thr1_derate_w;
    logic [NCH-1:0]   thr_half_w;
    int               failures = 0;
    int               n_compared = 0;
    always #4 clk = ~clk;
    ofp_host host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    ofp_core #(.P_W1(W1), .P_W2(W2), .P_W3(W3), .P_RESTART(RS), .P_BLANK(20)) dut_u (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .fail_mode_in(fail_mode_in), .die_hot_in(die_hot_in), .oc_raw(oc_raw),
        .ssc_raw(ssc_raw), .warn_hi_raw(warn_hi_raw), .warn_lo_raw(warn_lo_raw),
        .shut_raw(shut_raw), .vout_low_raw(vout_low_raw), .out_en(out_en_w),
        .inrush_level(inrush_level_w), .thr1_derate(thr1_derate_w), .thr_half(thr_half_w));
    // outputs copied at the falling edge, so a check never races the edge that updates them
    always @(negedge clk) begin
        out_en       <= out_en_w;
        inrush_level <= inrush_level_w;
        thr1_derate  <= thr1_derate_w;
        thr_half     <= thr_half_w;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        host_u.read(a, d);
        chk(nm, e, d);
    endtask
    // stage checked a few cycles clear of each window edge
    task automatic windows(input int c, input int a, input int b, input int w);
        cyc(a - 6);
        chk("stage1", 32'(STG_W1), 32'(inrush_level[3*c +: 3]));
        cyc(12);
        chk("stage2", 32'(STG_W2), 32'(inrush_level[3*c +: 3]));
        cyc(b);
        chk("stage3", 32'(STG_W3), 32'(inrush_level[3*c +: 3]));
        cyc(w);
        chk("steady", 32'(STG_STEADY), 32'(inrush_level[3*c +: 3]));
    endtask
    task automatic print_verdict;
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #80000;
        failures++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(10);
        rst <= 1'b0;
        warn_hi_raw <= 5'h01;
        rchk("cfg", ADDR_CFG, 32'(CFG_RST));
        cyc(2);
        rchk("blank", ADDR_QSTAT, 32'h0);
        warn_hi_raw <= 5'h00;
        rchk("unmapped", 8'hfc, 32'h0);
        die_hot_in <= 1'b1;
        vout_low_raw <= 5'h1f;
        host_u.write(ADDR_OUT_CTRL, 32'h01);
        cyc(8);
        chk("thr1 off", 32'h0, 32'(thr1_derate));
        chk("half off", 32'h0, 32'(thr_half));
        host_u.write(ADDR_CFG, 32'h3);
        cyc(4);
        chk("thr1 on", 32'h1, 32'(thr1_derate));
        chk("half on", 32'h01, 32'(thr_half));
        vout_low_raw <= 5'h00;
        die_hot_in <= 1'b0;
        cyc(8);
        chk("half hi", 32'h0, 32'(thr_half));
        chk("thr1 cool", 32'h0, 32'(thr1_derate));
        host_u.write(ADDR_CFG, 32'h0);
        host_u.write(ADDR_OUT_CTRL, 32'h03);
        windows(1, W1, W2, W3);
        host_u.write(ADDR_CH_CTRL0 + 8'h08, 32'h3);
        windows(2, W1 / 2, W2 / 2, W3 / 2);
        warn_lo_raw <= 5'h01;
        cyc(8);
        rchk("lo unsel", ADDR_QSTAT, 32'h0);
        warn_hi_raw <= 5'h01;
        cyc(8);
        rchk("warn q", ADDR_QSTAT, 32'h1);
        chk("warn out", 32'h07, 32'(out_en));
        host_u.write(ADDR_CFG, 32'h4);
        warn_hi_raw <= 5'h00;
        cyc(8);
        rchk("warn held", ADDR_CH_STAT0, 32'h49);
        warn_lo_raw <= 5'h00;
        cyc(8);
        rchk("warn last", ADDR_CH_STAT0, 32'h49);
        rchk("warn gone", ADDR_CH_STAT0, 32'h48);
        shut_raw <= 5'h01;
        cyc(300);
        shut_raw <= 5'h00;
        cyc(10);
        shut_raw <= 5'h01;
        cyc(600);
        chk("ot glitch", 32'h07, 32'(out_en));
        cyc(60);
        chk("ot off", 32'h06, 32'(out_en));
        rchk("ot q", ADDR_QSTAT, 32'h20);
        host_u.write(ADDR_OUT_CTRL, 32'h07);
        cyc(4);
        chk("ot hot on", 32'h06, 32'(out_en));
        shut_raw <= 5'h00;
        cyc(8);
        rchk("ot latch", ADDR_CH_STAT0, 32'h02);
        rchk("ot clear", ADDR_CH_STAT0, 32'h00);
        host_u.write(ADDR_OUT_CTRL, 32'h07);
        cyc(4);
        chk("ot restart", 32'h07, 32'(out_en));
        oc_raw <= 5'h02;
        cyc(230);
        chk("oc glitch", 32'h07, 32'(out_en));
        cyc(40);
        chk("oc off", 32'h05, 32'(out_en));
        fail_mode_in <= 1'b1;
        oc_raw <= 5'h01;
        cyc(270);
        oc_raw <= 5'h00;
        chk("fail oc", 32'h0, 32'(out_en[0]));
        cyc(RS - 30);
        chk("no early", 32'h0, 32'(out_en[0]));
        cyc(50);
        chk("auto on", 32'h1, 32'(out_en[0]));
        shut_raw <= 5'h01;
        ssc_raw <= 5'h02;
        cyc(700);
        shut_raw <= 5'h00;
        ssc_raw <= 5'h00;
        cyc(RS + 50);
        chk("fail latch", 32'h0, 32'(out_en[1:0]));
        fail_mode_in <= 1'b0;
        cyc(8);
        chk("mode only", 32'h3, 32'(out_en[1:0]));
        host_u.write(ADDR_OUT_CTRL, 32'h07);
        cyc(4);
        chk("mode back", 32'h3, 32'(out_en[1:0]));
        print_verdict();
    end
endmodule
